// ===== design/sdp_pkg.sv
// constants shared by the serial display command port
package sdp_pkg;
    // transfer framing: header byte then payload byte
    localparam int WORD_BITS = 16;
    localparam int BIT_RW = 15;
    localparam int BIT_DC = 14;
    localparam int BIT_HL = 13;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_HDR_LAST = 4'h7;
    localparam logic [3:0] CNT_LAST = 4'hF;
    localparam logic [3:0] CNT_STEP = 4'h1;
    // command codes
    localparam logic [15:0] CMD_NONE = 16'h0000;
    localparam logic [15:0] CMD_RAMWR = 16'h2C00;
    localparam logic [15:0] CMD_RAMRD = 16'h2E00;
    localparam logic [15:0] CMD_PIXFMT = 16'h3A00;
    localparam logic [15:0] CMD_IFCTL = 16'hB300;
    localparam int ICM_BIT = 0;
    // pixel formats
    localparam logic [7:0] FMT_565 = 8'h05;
    localparam logic [7:0] FMT_666 = 8'h06;
    localparam logic [7:0] FMT_888 = 8'h07;
    // interface mode strap codes
    localparam logic [2:0] IM_RGB_SPI = 3'h3;
    localparam logic [2:0] IM_MDDI_SPI = 3'h6;
    // colour byte order on memory read
    localparam logic [1:0] COLOR_R = 2'h0;
    localparam logic [1:0] COLOR_G = 2'h1;
    localparam logic [1:0] COLOR_B = 2'h2;
    localparam logic [1:0] IDX_ZERO = 2'h0;
    localparam logic [1:0] IDX_STEP = 2'h1;
    // synchroniser reset: chip select idle high
    localparam logic [2:0] SYNC_RST = 3'h1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    typedef enum logic [1:0] {SRC_REG, SRC_DUMMY, SRC_PIX} sdp_rd_src_t;
endpackage

// ===== design/sdp_fifo2.sv
// small shift-register buffer with valid/ready on both sides
`timescale 1ns/1ps
module sdp_fifo2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    input wire logic ref_clk,                 // clock
    input wire logic rst,                     // async reset, high
    input wire logic clk_en,                  // freeze when low
    input wire logic in_valid,                // write request
    output logic in_ready,                    // room for a word
    input wire logic [WIDTH-1:0] in_data,     // write word
    output logic out_valid,                   // head word valid
    input wire logic out_ready,               // reader takes head
    output logic [WIDTH-1:0] out_data         // head word
);
    localparam int CW = $clog2(DEPTH + 1);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [WIDTH-1:0] mem_d [DEPTH];
    logic [CW-1:0] cnt_q;
    logic valid_q;
    // handshake decode
    wire push = in_valid & in_ready & clk_en;
    wire pop = valid_q & out_ready & clk_en;
    wire [CW-1:0] wr_idx = cnt_q - CW'(pop);
    wire [CW-1:0] cnt_d = cnt_q + CW'(push) - CW'(pop);
    assign in_ready = cnt_q != CW'(DEPTH);
    assign out_valid = valid_q;
    assign out_data = mem_q[0];
    // shift toward the head on pop, write at tail
    always_comb begin
        for (int i = 0; i < DEPTH; i++) begin
            mem_d[i] = (pop && i < DEPTH - 1) ? mem_q[(i == DEPTH - 1) ? i : i + 1] : mem_q[i];
            if (push && wr_idx == CW'(i)) begin
                mem_d[i] = in_data;
            end
        end
    end
    // storage and count
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem_q[i] <= '0;
            end
            cnt_q <= '0;
            valid_q <= 1'b0;
        end else if (clk_en) begin
            mem_q <= mem_d;
            cnt_q <= cnt_d;
            valid_q <= cnt_d != '0;
        end
    end
endmodule

// ===== design/sdp_port.sv
// serial display command port: 16-bit serial slave with pixel write and read
//
// Function
// - port works only when the mode straps select a serial mode.
// - edge strap low uses rising serial clock, high uses falling.
// - chip select high holds the port idle, clock and data ignored.
// - chip select falling starts a transfer, clock level irrelevant.
// - input bits are captured on the capture clock edge.
// - first bit is direction: one read, zero write.
// - chip select staying low makes the next edge a new direction bit.
// - output changes on launch edges; host samples on capture edges.
// - memory read starts with one 16-clock dummy transfer; registers none.
// - a stopped serial clock between transfers is harmless.
// - memory writes only in the RGB and MDDI combined modes.
// - RGB mode needs the interface-control bit set for memory writes.
// - MDDI mode accepts writes only while MDDI is not writing.
// - pixel format parameter selects 5-6-5, 6-6-6 or 8-8-8 data.
// - data/command flag: zero command, one data; writes use direction zero.
// - memory read returns red, green, blue bytes of 8 bits.
// - memory read uses the 2E00h command code.
// - pause: select high between bytes keeps the byte and colour position, so the sequence resumes at the next byte.
// - select rising mid-byte drops partial bits, same byte expected again.
`timescale 1ns/1ps
module sdp_port #(
    parameter int AW = 19,
    parameter int DEPTH = 2,
    parameter logic [2:0] SPI_ONLY_MODE = 3'h1
) (
    input wire logic ref_clk,                      // 100 MHz clock
    input wire logic rst,                          // async reset, high
    input wire logic clk_en,                       // freeze when low
    input wire logic clock_edge_select_strap,      // edge strap
    input wire logic [2:0] interface_mode_straps,  // mode straps
    input wire logic chip_select_n,                // select pin, low
    input wire logic serial_clk,                   // serial clock pin
    input wire logic serial_in,                    // serial data in pin
    output logic serial_out,                       // serial data out
    output logic serial_out_oe,                    // drive serial_out
    input wire logic mddi_ram_busy,                // mddi writing memory
    input wire logic [7:0] reg_rd_data,            // register read byte
    input wire logic [23:0] mem_rd_data,           // pixel read word
    output logic mem_rd_req,                       // fetch next pixel
    output logic cmd_valid,                        // command strobe
    output logic [15:0] cmd_code,                  // current command
    output logic param_valid,                      // parameter strobe
    output logic [7:0] param_byte,                 // parameter byte
    input wire logic [AW-1:0] window_start,        // window first address
    input wire logic [AW-1:0] window_end,          // window last address
    output logic pix_valid,                        // pixel available
    input wire logic pix_ready,                    // memory takes pixel
    output logic [23:0] pix_data,                  // pixel 8-8-8
    output logic [AW-1:0] pix_addr,                // pixel address
    output logic port_active,                      // port enabled
    output logic [7:0] pixel_format,               // format parameter
    output logic serial_ram_write_enable,          // interface-control bit
    output logic pixel_overrun                     // sticky pixel drop
);
    // pin synchroniser: bit0 select, bit1 clock, bit2 data
    logic [2:0] sy1_q, sy2_q, sy3_q, lvl_q;
    wire [2:0] pins = {serial_in, serial_clk, chip_select_n};
    wire [2:0] agree = ~(sy2_q ^ sy3_q);
    wire [2:0] lvl_d = (agree & sy3_q) | (~agree & lvl_q);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sy1_q <= sdp_pkg::SYNC_RST;
            sy2_q <= sdp_pkg::SYNC_RST;
            sy3_q <= sdp_pkg::SYNC_RST;
            lvl_q <= sdp_pkg::SYNC_RST;
        end else if (clk_en) begin
            sy1_q <= pins;
            sy2_q <= sy1_q;
            sy3_q <= sy2_q;
            lvl_q <= lvl_d;
        end
    end

    // straps caught once after reset release
    logic strap_done_q, edge_sel_q;
    logic [2:0] mode_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            strap_done_q <= 1'b0;
            edge_sel_q <= 1'b0;
            mode_q <= 3'h0;
        end else if (clk_en && !strap_done_q) begin
            strap_done_q <= 1'b1;
            edge_sel_q <= clock_edge_select_strap;
            mode_q <= interface_mode_straps;
        end
    end

    // mode and edge decode
    wire mode_rgb = mode_q == sdp_pkg::IM_RGB_SPI;
    wire mode_mddi = mode_q == sdp_pkg::IM_MDDI_SPI;
    wire mode_spi = mode_rgb | mode_mddi | (mode_q == SPI_ONLY_MODE);
    wire port_en = strap_done_q & mode_spi;
    wire cs_idle = lvl_q[0];
    wire hold_idle = ~port_en | cs_idle;
    wire sck_rise = ~lvl_q[1] & lvl_d[1];
    wire sck_fall = lvl_q[1] & ~lvl_d[1];
    wire sdi_bit = lvl_d[2];
    wire cap_edge = ~hold_idle & (edge_sel_q ? sck_fall : sck_rise);
    wire launch_edge = ~hold_idle & (edge_sel_q ? sck_rise : sck_fall);

    // bit counter and input shifter; clock may stop between words
    logic [3:0] bit_cnt_q;
    logic [14:0] sr_q;
    logic rw_q;
    wire [15:0] word = {sr_q, sdi_bit};
    wire hdr_done = cap_edge && bit_cnt_q == sdp_pkg::CNT_HDR_LAST;
    wire word_done = cap_edge && bit_cnt_q == sdp_pkg::CNT_LAST;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            bit_cnt_q <= sdp_pkg::CNT_ZERO;
            sr_q <= '0;
            rw_q <= 1'b0;
        end else if (clk_en) begin
            if (hold_idle) begin
                bit_cnt_q <= sdp_pkg::CNT_ZERO;
            end else if (cap_edge) begin
                bit_cnt_q <= bit_cnt_q + sdp_pkg::CNT_STEP;
                sr_q <= word[14:0];
                if (bit_cnt_q == sdp_pkg::CNT_ZERO) begin
                    rw_q <= sdi_bit;
                end
            end
        end
    end

    // word decode
    logic [15:0] cmd_q;
    logic [7:0] cmd_hi_q, fmt_q;
    logic icm_q;
    wire [7:0] pay = word[7:0];
    wire wr_done = word_done & ~word[sdp_pkg::BIT_RW];
    wire rd_done = word_done & word[sdp_pkg::BIT_RW];
    wire is_dc = word[sdp_pkg::BIT_DC];
    wire is_hl = word[sdp_pkg::BIT_HL];
    wire cmd_hi = wr_done & ~is_dc & is_hl;
    wire cmd_lo = wr_done & ~is_dc & ~is_hl;
    wire [15:0] new_cmd = {cmd_hi_q, pay};
    wire data_wr = wr_done & is_dc;
    wire in_ramwr = cmd_q == sdp_pkg::CMD_RAMWR;
    wire ram_ok = (mode_rgb & icm_q) | (mode_mddi & ~mddi_ram_busy);
    wire ram_byte = data_wr & in_ramwr & ram_ok;
    wire par_byte = data_wr & ~in_ramwr;
    wire par_lo = par_byte & ~is_hl;

    // command registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmd_hi_q <= sdp_pkg::BYTE_ZERO;
            cmd_q <= sdp_pkg::CMD_NONE;
            cmd_valid <= 1'b0;
        end else if (clk_en) begin
            cmd_valid <= cmd_lo;
            if (cmd_hi) begin
                cmd_hi_q <= pay;
            end
            if (cmd_lo) begin
                cmd_q <= new_cmd;
            end
        end
    end
    assign cmd_code = cmd_q;

    // parameter bytes, pixel format and interface-control bit
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            param_valid <= 1'b0;
            param_byte <= sdp_pkg::BYTE_ZERO;
            fmt_q <= sdp_pkg::FMT_888;
            icm_q <= 1'b0;
        end else if (clk_en) begin
            param_valid <= par_byte;
            if (par_byte) begin
                param_byte <= pay;
            end
            if (par_lo && cmd_q == sdp_pkg::CMD_PIXFMT) begin
                fmt_q <= pay;
            end
            if (par_lo && cmd_q == sdp_pkg::CMD_IFCTL) begin
                icm_q <= pay[sdp_pkg::ICM_BIT];
            end
        end
    end
    assign pixel_format = fmt_q;
    assign serial_ram_write_enable = icm_q;

    // pixel assembly per format, widened to 8-8-8
    logic [1:0] byte_idx_q;
    logic [15:0] acc_q;
    logic [AW-1:0] wr_addr_q;
    logic overrun_q, buf_in_ready;
    wire is_565 = fmt_q == sdp_pkg::FMT_565;
    wire is_666 = fmt_q == sdp_pkg::FMT_666;
    localparam logic [1:0] COLOR_LAST = sdp_pkg::COLOR_B;
    wire last_565 = is_565 && byte_idx_q == sdp_pkg::IDX_STEP;
    wire last_3b = ~is_565 && byte_idx_q == COLOR_LAST;
    wire pix_done = ram_byte & (last_565 | last_3b);
    wire [23:0] pix_565 = {acc_q[7:3], 3'h0, acc_q[2:0], pay[7:5], 2'h0, pay[4:0], 3'h0};
    wire [23:0] pix_666 = {acc_q[15:10], 2'h0, acc_q[7:2], 2'h0, pay[7:2], 2'h0};
    wire [23:0] pix_888 = {acc_q, pay};
    wire [23:0] pix_word = is_565 ? pix_565 : (is_666 ? pix_666 : pix_888);
    wire push = pix_done & buf_in_ready;
    wire drop = pix_done & ~buf_in_ready;
    wire ramwr_start = cmd_lo && new_cmd == sdp_pkg::CMD_RAMWR;
    wire [AW-1:0] addr_next = (wr_addr_q == window_end) ? window_start : wr_addr_q + AW'(1);
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            byte_idx_q <= sdp_pkg::IDX_ZERO;
            acc_q <= '0;
            wr_addr_q <= '0;
            overrun_q <= 1'b0;
        end else if (clk_en) begin
            if (ramwr_start) begin
                byte_idx_q <= sdp_pkg::IDX_ZERO;
                wr_addr_q <= window_start;
            end else if (ram_byte) begin
                byte_idx_q <= pix_done ? sdp_pkg::IDX_ZERO : byte_idx_q + sdp_pkg::IDX_STEP;
                acc_q <= {acc_q[7:0], pay};
                if (push) begin
                    wr_addr_q <= addr_next;
                end
            end
            overrun_q <= overrun_q | drop;
        end
    end
    assign pixel_overrun = overrun_q;

    // two-entry buffer toward the frame memory
    sdp_fifo2 #(
        .WIDTH(AW + 24),
        .DEPTH(DEPTH)
    ) u_buf (
        .ref_clk(ref_clk),
        .rst(rst),
        .clk_en(clk_en),
        .in_valid(pix_done),
        .in_ready(buf_in_ready),
        .in_data({wr_addr_q, pix_word}),
        .out_valid(pix_valid),
        .out_ready(pix_ready),
        .out_data({pix_addr, pix_data})
    );

    // read source sequencing
    localparam logic [1:0] IDX_ONE = sdp_pkg::IDX_STEP;
    sdp_pkg::sdp_rd_src_t rd_src_q, rd_src_d;
    logic [1:0] color_q, color_d;
    logic mem_req_d;
    always_comb begin
        rd_src_d = rd_src_q;
        color_d = color_q;
        mem_req_d = 1'b0;
        if (cmd_lo) begin
            rd_src_d = (new_cmd == sdp_pkg::CMD_RAMRD) ? sdp_pkg::SRC_DUMMY : sdp_pkg::SRC_REG;
            color_d = sdp_pkg::COLOR_R;
            mem_req_d = new_cmd == sdp_pkg::CMD_RAMRD;
        end else if (rd_done) begin
            case (rd_src_q)
                sdp_pkg::SRC_DUMMY: begin
                    rd_src_d = sdp_pkg::SRC_PIX;
                end
                sdp_pkg::SRC_PIX: begin
                    color_d = (color_q == sdp_pkg::COLOR_B) ? sdp_pkg::COLOR_R : color_q + IDX_ONE;
                    mem_req_d = color_q == sdp_pkg::COLOR_B;
                end
                default: begin
                    rd_src_d = rd_src_q;
                end
            endcase
        end
    end
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            rd_src_q <= sdp_pkg::SRC_REG;
            color_q <= sdp_pkg::COLOR_R;
            mem_rd_req <= 1'b0;
        end else if (clk_en) begin
            rd_src_q <= rd_src_d;
            color_q <= color_d;
            mem_rd_req <= mem_req_d;
        end
    end

    // read byte selection: dummy, register or colour byte
    wire [7:0] pix_byte = (color_q == sdp_pkg::COLOR_R) ? mem_rd_data[23:16] :
        ((color_q == sdp_pkg::COLOR_G) ? mem_rd_data[15:8] : mem_rd_data[7:0]);
    wire [7:0] rd_byte = (rd_src_q == sdp_pkg::SRC_PIX) ? pix_byte :
        ((rd_src_q == sdp_pkg::SRC_DUMMY) ? sdp_pkg::BYTE_ZERO : reg_rd_data);
    wire rd_hdr = hdr_done & rw_q;

    // output shifter, shifted on launch edges; output and enable cleared while select is idle
    logic [7:0] out_sr_q;
    logic rd_act_q, sout_q, oe_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            out_sr_q <= sdp_pkg::BYTE_ZERO;
            rd_act_q <= 1'b0;
            sout_q <= 1'b0;
            oe_q <= 1'b0;
        end else if (clk_en) begin
            if (hold_idle) begin
                rd_act_q <= 1'b0;
                sout_q <= 1'b0;
                oe_q <= 1'b0;
            end else if (rd_hdr) begin
                out_sr_q <= rd_byte;
                rd_act_q <= 1'b1;
            end else if (word_done) begin
                rd_act_q <= 1'b0;
            end else if (launch_edge) begin
                sout_q <= rd_act_q ? out_sr_q[7] : 1'b0;
                out_sr_q <= {out_sr_q[6:0], 1'b0};
                oe_q <= rd_act_q;
            end
        end
    end
    assign serial_out = sout_q;
    assign serial_out_oe = oe_q;

    // port enable flag
    logic active_q;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            active_q <= 1'b0;
        end else if (clk_en) begin
            active_q <= port_en;
        end
    end
    assign port_active = active_q;

    // checks
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_idle_clears: assert property (clk_en && hold_idle |=> bit_cnt_q == 4'h0 && !serial_out_oe)
        else $error("idle select did not clear the port");
    a_port_off: assert property (!port_en |-> !serial_out_oe && !cmd_valid && !param_valid)
        else $error("port active while straps deselect it");
    a_cnt_hold: assert property (clk_en && !hold_idle && !cap_edge |=> $stable(bit_cnt_q))
        else $error("bit counter moved without a capture edge");
    a_cnt_step: assert property (clk_en && cap_edge |=> bit_cnt_q == $past(bit_cnt_q) + 4'h1)
        else $error("bit counter did not step on capture edge");
    a_out_launch: assert property ($changed(serial_out) |-> $past(launch_edge) || $past(hold_idle))
        else $error("serial output changed off a launch edge");
    a_oe_read: assert property (serial_out_oe |-> rw_q)
        else $error("output driven during a write transfer");
    a_dummy_zero: assert property (clk_en && rd_hdr && rd_src_q == sdp_pkg::SRC_DUMMY |=> out_sr_q == 8'h00)
        else $error("dummy transfer did not return zero");
    a_red_first: assert property (clk_en && rd_hdr && rd_src_q == sdp_pkg::SRC_PIX && color_q == sdp_pkg::COLOR_R
        |=> out_sr_q == $past(mem_rd_data[23:16]))
        else $error("memory read did not start with red");
    a_ram_gate: assert property (pix_done |-> cmd_code == sdp_pkg::CMD_RAMWR &&
        ((mode_q == sdp_pkg::IM_RGB_SPI && serial_ram_write_enable) ||
        (mode_q == sdp_pkg::IM_MDDI_SPI && !mddi_ram_busy)))
        else $error("pixel accepted while memory writes are gated");
    a_addr_step: assert property (clk_en && push && wr_addr_q != window_end
        |=> wr_addr_q == $past(wr_addr_q) + 1'b1) else $error("write address did not advance");
    a_fmt_bytes: assert property (pix_done && is_565 |-> byte_idx_q == 2'h1)
        else $error("5-6-5 pixel not closed on second byte");
    c_pixel_push: cover property (push);
    c_mem_read: cover property (rd_done && rd_src_q == sdp_pkg::SRC_PIX);
    c_reg_read: cover property (rd_done && rd_src_q == sdp_pkg::SRC_REG);
    c_overrun: cover property (drop);
endmodule

// ===== bench/sdp_host_model.sv
// host-side serial master model driving the command port pins
`timescale 1ns/1ps
module sdp_host_model (
    input wire logic ref_clk,       // bench clock
    input wire logic serial_out,    // device data out
    input wire logic serial_out_oe, // device drives data
    input wire logic fall_mode,     // active clock edge is falling
    output logic chip_select_n,     // select, low
    output logic serial_clk,        // serial clock pin
    output logic serial_in          // serial data in
);
    // pins idle: deselected, clock stopped
    initial begin
        chip_select_n = 1'b1;
        serial_clk = 1'b0;
        serial_in = 1'b1;
    end
    // n bits msb first; data moves on the launch edge, read data taken before the capture edge
    task automatic xfer(input logic [15:0] w, input int n, output logic [7:0] rd);
        chip_select_n <= 1'b0;
        for (int i = 15; i > 15 - n; i--) begin
            if (w[15] && i < 8) serial_in <= ~serial_in;
            else serial_in <= w[i];
            repeat (5) @(posedge ref_clk);
            rd = {rd[6:0], serial_out};
            serial_clk <= ~fall_mode;
            repeat (4) @(posedge ref_clk);
            serial_clk <= fall_mode;
        end
    endtask
    // end of frame: select raised, clock stays stopped
    task automatic done();
        repeat (8) @(posedge ref_clk);
        chip_select_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        serial_clk <= fall_mode;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// ===== bench/sdp_port_tb_top.sv
// self-checking bench for the serial display command port
`timescale 1ns/1ps
module sdp_port_tb_top;
    logic ref_clk, rst, mddi_ram_busy, pix_ready, serial_out, serial_out_oe;
    logic chip_select_n, serial_clk, serial_in, mem_rd_req, cmd_valid, param_valid;
    logic pix_valid, port_active, serial_ram_write_enable, pixel_overrun;
    logic [7:0] reg_rd_data, param_byte, pixel_format, rd;
    logic edge_strap;
    logic [2:0] mode_straps;
    logic [15:0] cmd_code;
    logic [23:0] mem_rd_data, pix_data;
    logic [18:0] window_start, window_end, pix_addr;
    logic [47:0] pq[$];
    int err_total, samples_checked;
    int cmd_seen, req_seen;

    sdp_port dut_u (.ref_clk, .rst, .clk_en(1'b1), .clock_edge_select_strap(edge_strap),
        .interface_mode_straps(mode_straps), .chip_select_n, .serial_clk, .serial_in, .serial_out,
        .serial_out_oe, .mddi_ram_busy, .reg_rd_data, .mem_rd_data, .mem_rd_req, .cmd_valid,
        .cmd_code, .param_valid, .param_byte, .window_start, .window_end, .pix_valid,
        .pix_ready, .pix_data, .pix_addr, .port_active, .pixel_format,
        .serial_ram_write_enable, .pixel_overrun);
    sdp_host_model host_u (.ref_clk, .serial_out, .serial_out_oe, .fall_mode(edge_strap), .chip_select_n,
        .serial_clk, .serial_in);

    // 100 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // pixels taken by the memory side, address over data
    always @(posedge ref_clk) if (pix_valid && pix_ready) pq.push_back({5'h0, pix_addr, pix_data});
    // pulse counters for command and fetch strobes
    always @(posedge ref_clk) begin
        cmd_seen += cmd_valid;
        req_seen += mem_rd_req;
    end

    task automatic chk(input string nm, input logic [47:0] exp, input logic [47:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] w);
        host_u.xfer(w, 16, rd);
    endtask
    // command: high byte word then low byte word
    task automatic cmd(input logic [15:0] c);
        wr({8'h20, c[15:8]});
        wr({8'h00, c[7:0]});
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask

    // watchdog
    initial begin
        #500000;
        err_total++;
        final_report();
    end

    // main sequence
    initial begin
        rst = 1'b1;
        edge_strap = 1'b0;
        mode_straps = sdp_pkg::IM_RGB_SPI;
        mddi_ram_busy = 1'b0;
        pix_ready = 1'b0;
        reg_rd_data = 8'hA5;
        mem_rd_data = 24'h12_3456;
        window_start = 19'h0_0010;
        window_end = 19'h0_0011;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (12) @(posedge ref_clk);
        chk("port_active", 1, port_active);
        host_u.xfer(16'h203A, 8, rd);
        host_u.done();
        cmd(16'h3A00);
        wr(16'h4005);
        host_u.done();
        chk("pixel_format", sdp_pkg::FMT_565, pixel_format);
        chk("param_byte", 8'h05, param_byte);
        cmd(16'hB300);
        wr(16'h4001);
        host_u.done();
        chk("ram_wr_en", 1, serial_ram_write_enable);
        cmd(16'h2C00);
        repeat (2) @(posedge ref_clk);
        chk("cmd_code", sdp_pkg::CMD_RAMWR, cmd_code);
        for (int i = 0; i < 3; i++) begin
            wr(16'h40F8);
            wr(16'h401F);
        end
        host_u.done();
        chk("overrun", 1, pixel_overrun);
        chk("stalled", 0, pq.size());
        pix_ready <= 1'b1;
        wr(16'h40F8);
        wr(16'h401F);
        host_u.done();
        chk("pix0", {24'h10, 24'hF800F8}, pq[0]);
        chk("pix1", {24'h11, 24'hF800F8}, pq[1]);
        chk("pix_wrap", {24'h10, 24'hF800F8}, pq[2]);
        cmd(16'hB300);
        wr(16'h4000);
        cmd(16'h2C00);
        wr(16'h40F8);
        wr(16'h401F);
        host_u.done();
        chk("gated", 3, pq.size());
        host_u.xfer(16'h8000, 16, rd);
        host_u.done();
        chk("reg_read", 8'hA5, rd);
        cmd(16'h2E00);
        for (int i = 0; i < 4; i++) begin
            host_u.xfer(16'h8000, 16, rd);
            chk("mem_read", (i == 0) ? 8'h00 : mem_rd_data[23 - 8 * (i - 1) -: 8], rd);
        end
        host_u.done();
        chk("mem_rd_req", 2, req_seen);
        chk("cmd_count", 6, cmd_seen);
        // reset mid-run: falling capture edge in the memory-interface combined mode
        rst <= 1'b1;
        edge_strap <= 1'b1;
        mode_straps <= sdp_pkg::IM_MDDI_SPI;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        host_u.done();
        chk("active_fall", 1, port_active);
        chk("format_rst", sdp_pkg::FMT_888, pixel_format);
        cmd(16'h2C00);
        wr(16'h4012);
        wr(16'h4034);
        wr(16'h4056);
        host_u.done();
        chk("pix_fall", {24'h10, 24'h12_3456}, pq[3]);
        mddi_ram_busy <= 1'b1;
        cmd(16'h2C00);
        wr(16'h4012);
        wr(16'h4034);
        wr(16'h4056);
        host_u.done();
        chk("mddi_busy", 4, pq.size());
        host_u.xfer(16'h8000, 16, rd);
        host_u.done();
        chk("reg_read_fall", 8'hA5, rd);
        chk("oe_idle", 0, serial_out_oe);
        // straps selecting no serial mode keep the port off
        rst <= 1'b1;
        mode_straps <= 3'h0;
        repeat (4) @(posedge ref_clk);
        rst <= 1'b0;
        host_u.done();
        chk("port_off", 0, port_active);
        cmd(16'h3A00);
        host_u.done();
        chk("cmd_ignored", sdp_pkg::CMD_NONE, cmd_code);
        final_report();
    end
endmodule
